// file: rtl/csp_pkg.sv
// Package: register map, field layout and timing constants of the core status and power block
// ==========================================================================
package csp_pkg;

	localparam logic [7:0] ADDR_POINTER_LOW   = 8'h82;
	localparam logic [7:0] ADDR_POINTER_HIGH  = 8'h83;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
	localparam logic [7:0] ADDR_STATUS_WORD   = 8'hd0;
	localparam logic [7:0] ADDR_ACCUMULATOR   = 8'he0;
	localparam logic [7:0] ADDR_SECOND_OP     = 8'hf0;
	localparam logic [7:0] ADDR_POWER_STATE   = 8'hc7;

	localparam logic [7:0] RESET_BYTE    = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	localparam int BIT_CARRY  = 7;
	localparam int BIT_HALF   = 6;
	localparam int BIT_USER_A = 5;
	localparam int BIT_BANK_HI = 4;
	localparam int BIT_BANK_LO = 3;
	localparam int BIT_OVER   = 2;
	localparam int BIT_USER_B = 1;
	localparam int BIT_PARITY = 0;
	localparam int BIT_IDLE   = 0;
	localparam int BIT_STOP   = 1;

	localparam int CLOCK_HZ          = 25000000;
	localparam int DETECTOR_TIMEOUT_US = 100;
	localparam int DETECTOR_CYCLES   = (CLOCK_HZ / 1000000) * DETECTOR_TIMEOUT_US;
	localparam int WATCHDOG_CYCLES   = 65536;

	typedef enum logic [2:0] {
		CSP_OP_NONE,
		CSP_OP_ADD,
		CSP_OP_ADD_WITH_CARRY,
		CSP_OP_SUBTRACT_WITH_BORROW,
		CSP_OP_MULTIPLY,
		CSP_OP_DIVIDE,
		CSP_OP_OTHER_ARITH
	} csp_op_type;

	typedef enum logic [1:0] {
		CSP_RUN,
		CSP_IDLE,
		CSP_STOP,
		CSP_SUSPEND
	} csp_power_type;

	typedef struct packed {
		csp_op_type op;
		logic [7:0] operand;
	} csp_alu_req_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       write;
		logic       read;
	} csp_bus_type;

endpackage

// file: rtl/csp_core_status.sv
// Core status word, accumulators, data pointer and idle/stop/suspend power control
`timescale 1ns/1ps
module csp_core_status
	import csp_pkg::*;
#(
	parameter int WATCHDOG_LIMIT = WATCHDOG_CYCLES,
	parameter int DETECTOR_LIMIT = DETECTOR_CYCLES
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire csp_bus_type      bus,
	output logic [7:0]            rdata,
	input  wire csp_alu_req_type  alu_req,
	input  wire logic             instr_done,
	input  wire logic             irq_enabled_pin,
	input  wire logic             wake_event_pin,
	input  wire logic             watchdog_enable,
	input  wire logic             detector_enable,
	output logic [15:0]           data_pointer,
	output logic [4:0]            bank_base,
	output logic                  cpu_clock_enable,
	output logic                  periph_clock_enable,
	output logic                  oscillator_enable,
	output logic                  internal_reset,
	output logic [15:0]           fetch_address
);

	// ==========================================================================
	// Storage
	logic [7:0]    pointer_low;
	logic [7:0]    pointer_high;
	logic [7:0]    accumulator;
	logic [7:0]    second_operand_reg;
	logic          carry_flag;
	logic          half_carry_flag;
	logic          user_flag_a;
	logic          user_flag_b;
	logic          bank_select_hi;
	logic          bank_select_lo;
	logic          overflow_flag;
	csp_power_type power_state;
	logic          idle_pending;
	logic          stop_pending;
	logic [1:0]    irq_sync;
	logic [1:0]    wake_sync;
	logic [16:0]   watchdog_count;
	logic [11:0]   detector_count;
	logic          reset_seen;

	function automatic logic bus_hit(input csp_bus_type b, input logic [7:0] a);
		return b.write && (b.addr == a);
	endfunction

	wire parity_bit = ^accumulator;
	wire [7:0] status_word = {carry_flag, half_carry_flag, user_flag_a, bank_select_hi,
		bank_select_lo, overflow_flag, user_flag_b, parity_bit};

	// ==========================================================================
	// Arithmetic results
	logic [8:0]  next_sum;
	logic [4:0]  next_nib;
	logic [15:0] next_prod;
	logic        next_carry;
	logic        next_half;
	logic        next_over;
	logic [7:0]  next_acc;
	logic [7:0]  next_second;
	logic        alu_act;

	always_comb begin
		next_sum    = 9'h000;
		next_nib    = 5'h00;
		next_prod   = 16'h0000;
		next_carry  = 1'b0;
		next_half   = 1'b0;
		next_over   = 1'b0;
		next_acc    = accumulator;
		next_second = second_operand_reg;
		alu_act     = cpu_clock_enable;
		case (alu_req.op)
			CSP_OP_ADD, CSP_OP_ADD_WITH_CARRY: begin
				next_sum = {1'b0, accumulator} + {1'b0, alu_req.operand}
					+ {8'h00, alu_req.op == CSP_OP_ADD_WITH_CARRY && carry_flag};
				next_nib = {1'b0, accumulator[3:0]} + {1'b0, alu_req.operand[3:0]}
					+ {4'h0, alu_req.op == CSP_OP_ADD_WITH_CARRY && carry_flag};
				next_carry = next_sum[8];
				next_half  = next_nib[4];
				next_over  = (accumulator[7] == alu_req.operand[7]) && (next_sum[7] != accumulator[7]);
				next_acc   = next_sum[7:0];
			end
			CSP_OP_SUBTRACT_WITH_BORROW: begin
				next_sum = {1'b0, accumulator} - {1'b0, alu_req.operand} - {8'h00, carry_flag};
				next_nib = {1'b0, accumulator[3:0]} - {1'b0, alu_req.operand[3:0]} - {4'h0, carry_flag};
				next_carry = next_sum[8];
				next_half  = next_nib[4];
				next_over  = (accumulator[7] != alu_req.operand[7]) && (next_sum[7] != accumulator[7]);
				next_acc   = next_sum[7:0];
			end
			CSP_OP_MULTIPLY: begin
				next_prod   = accumulator * second_operand_reg;
				next_over   = next_prod[15:8] != 8'h00;
				next_acc    = next_prod[7:0];
				next_second = next_prod[15:8];
			end
			CSP_OP_DIVIDE: begin
				next_over = second_operand_reg == 8'h00;
				if (!next_over) begin
					next_acc    = accumulator / second_operand_reg;
					next_second = accumulator % second_operand_reg;
				end
			end
			CSP_OP_OTHER_ARITH: begin
				next_carry = 1'b0;
				next_half  = 1'b0;
			end
			default: alu_act = 1'b0;
		endcase
	end

	// ==========================================================================
	// Status word
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			carry_flag      <= 1'b0;
			half_carry_flag <= 1'b0;
			user_flag_a     <= 1'b0;
			user_flag_b     <= 1'b0;
			bank_select_hi  <= 1'b0;
			bank_select_lo  <= 1'b0;
			overflow_flag   <= 1'b0;
		end else if (internal_reset) begin
			carry_flag      <= 1'b0;
			half_carry_flag <= 1'b0;
			user_flag_a     <= 1'b0;
			user_flag_b     <= 1'b0;
			bank_select_hi  <= 1'b0;
			bank_select_lo  <= 1'b0;
			overflow_flag   <= 1'b0;
		end else if (alu_act) begin
			carry_flag      <= next_carry;
			half_carry_flag <= next_half;
			if (alu_req.op != CSP_OP_OTHER_ARITH)
				overflow_flag <= next_over;
		end else if (bus_hit(bus, ADDR_STATUS_WORD)) begin
			carry_flag      <= bus.wdata[BIT_CARRY];
			half_carry_flag <= bus.wdata[BIT_HALF];
			user_flag_a     <= bus.wdata[BIT_USER_A];
			user_flag_b     <= bus.wdata[BIT_USER_B];
			bank_select_hi  <= bus.wdata[BIT_BANK_HI];
			bank_select_lo  <= bus.wdata[BIT_BANK_LO];
			overflow_flag   <= bus.wdata[BIT_OVER];
		end
	end

	// ==========================================================================
	// Accumulators and data pointer
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			accumulator        <= RESET_BYTE;
			second_operand_reg <= RESET_BYTE;
		end else if (internal_reset) begin
			accumulator        <= RESET_BYTE;
			second_operand_reg <= RESET_BYTE;
		end else if (alu_act) begin
			accumulator        <= next_acc;
			second_operand_reg <= next_second;
		end else begin
			if (bus_hit(bus, ADDR_ACCUMULATOR))
				accumulator <= bus.wdata;
			if (bus_hit(bus, ADDR_SECOND_OP))
				second_operand_reg <= bus.wdata;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pointer_low  <= RESET_BYTE;
			pointer_high <= RESET_BYTE;
		end else if (internal_reset) begin
			pointer_low  <= RESET_BYTE;
			pointer_high <= RESET_BYTE;
		end else begin
			if (bus_hit(bus, ADDR_POINTER_LOW))
				pointer_low <= bus.wdata;
			if (bus_hit(bus, ADDR_POINTER_HIGH))
				pointer_high <= bus.wdata;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			data_pointer <= {RESET_BYTE, RESET_BYTE};
			bank_base    <= 5'h00;
		end else begin
			data_pointer <= {pointer_high, pointer_low};
			bank_base    <= {bank_select_hi, bank_select_lo, 3'b000};
		end
	end

	// ==========================================================================
	// Synchronisers for pin-level wake sources
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_sync  <= 2'b00;
			wake_sync <= 2'b00;
		end else begin
			irq_sync  <= {irq_sync[0], irq_enabled_pin};
			wake_sync <= {wake_sync[0], wake_event_pin};
		end
	end

	// ==========================================================================
	// Power state; idle and stop triggers wait for the writing instruction to finish, suspend enters at once
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			power_state  <= CSP_RUN;
			idle_pending <= 1'b0;
			stop_pending <= 1'b0;
		end else if (internal_reset) begin
			power_state  <= CSP_RUN;
			idle_pending <= 1'b0;
			stop_pending <= 1'b0;
		end else begin
			// A trigger written in a completing cycle waits for the next completion
			if (bus_hit(bus, ADDR_POWER_CONTROL)) begin
				idle_pending <= idle_pending | bus.wdata[BIT_IDLE];
				stop_pending <= stop_pending | bus.wdata[BIT_STOP];
			end else if (instr_done) begin
				idle_pending <= 1'b0;
				stop_pending <= 1'b0;
			end
			case (power_state)
				CSP_RUN: begin
					if (instr_done && stop_pending)
						power_state <= CSP_STOP;
					else if (instr_done && idle_pending)
						power_state <= CSP_IDLE;
					else if (bus_hit(bus, ADDR_POWER_STATE) && bus.wdata[0])
						power_state <= CSP_SUSPEND;
				end
				CSP_IDLE: if (irq_sync[1])
					power_state <= CSP_RUN;
				// Only the reset and internal reset branches above leave stop
				CSP_STOP: power_state <= CSP_STOP;
				CSP_SUSPEND: if (wake_sync[1])
					power_state <= CSP_RUN;
				default: power_state <= CSP_RUN;
			endcase
		end
	end

	// ==========================================================================
	// Watchdog in idle and missing clock detector in stop
	// Detector runs off its own oscillator in silicon; modelled here on core_clk
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			watchdog_count <= 17'h00000;
			detector_count <= 12'h000;
			reset_seen     <= 1'b0;
		end else begin
			reset_seen <= 1'b0;
			if (watchdog_enable && power_state == CSP_IDLE) begin
				watchdog_count <= watchdog_count + 17'h00001;
				if (watchdog_count == 17'(WATCHDOG_LIMIT - 1)) begin
					watchdog_count <= 17'h00000;
					reset_seen     <= 1'b1;
				end
			end else
				watchdog_count <= 17'h00000;
			if (detector_enable && power_state == CSP_STOP) begin
				detector_count <= detector_count + 12'h001;
				if (detector_count == 12'(DETECTOR_LIMIT - 1)) begin
					detector_count <= 12'h000;
					reset_seen     <= 1'b1;
				end
			end else
				detector_count <= 12'h000;
		end
	end

	// ==========================================================================
	// Registered outputs
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			internal_reset      <= 1'b0;
			fetch_address       <= RESET_VECTOR;
			cpu_clock_enable    <= 1'b1;
			periph_clock_enable <= 1'b1;
			oscillator_enable   <= 1'b1;
		end else begin
			internal_reset <= reset_seen;
			if (reset_seen)
				fetch_address <= RESET_VECTOR;
			// Gate opens on the same edge as the state leaves idle, never mid-cycle
			cpu_clock_enable    <= (power_state == CSP_RUN && !(instr_done && (idle_pending || stop_pending)))
				|| (power_state == CSP_IDLE && irq_sync[1]);
			periph_clock_enable <= power_state != CSP_STOP && !(instr_done && stop_pending);
			oscillator_enable   <= power_state != CSP_STOP && power_state != CSP_SUSPEND;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			rdata <= 8'h00;
		else if (bus.read) begin
			case (bus.addr)
				ADDR_POINTER_LOW:   rdata <= pointer_low;
				ADDR_POINTER_HIGH:  rdata <= pointer_high;
				ADDR_POWER_CONTROL: rdata <= 8'h00;
				ADDR_STATUS_WORD:   rdata <= status_word;
				ADDR_ACCUMULATOR:   rdata <= accumulator;
				ADDR_SECOND_OP:     rdata <= second_operand_reg;
				ADDR_POWER_STATE:   rdata <= {6'h00, power_state};
				default:            rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

	// ==========================================================================
	// Checks
	a_parity_read: assert property (@(posedge core_clk) disable iff (reset)
		bus.read && bus.addr == ADDR_STATUS_WORD |=> rdata[0] == ^$past(accumulator)) else $error("parity bad");
	a_power_reads_zero: assert property (@(posedge core_clk) disable iff (reset)
		bus.read && bus.addr == ADDR_POWER_CONTROL |=> rdata == 8'h00) else $error("power control not zero");
	a_carry_add: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		cpu_clock_enable && alu_req.op == CSP_OP_ADD
		|=> carry_flag == (9'($past(accumulator)) + 9'($past(alu_req.operand)) > 9'h0ff)) else $error("carry bad");
	a_borrow_sub: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		cpu_clock_enable && alu_req.op == CSP_OP_SUBTRACT_WITH_BORROW
		|=> carry_flag == (9'($past(accumulator)) < 9'($past(alu_req.operand)) + 9'($past(carry_flag))))
		else $error("borrow bad");
	a_half_carry_add: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		cpu_clock_enable && alu_req.op == CSP_OP_ADD
		|=> half_carry_flag == (5'($past(accumulator[3:0])) + 5'($past(alu_req.operand[3:0])) > 5'h0f))
		else $error("half carry bad");
	a_user_flags: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		bus_hit(bus, ADDR_STATUS_WORD) && !alu_act
		|=> user_flag_a == $past(bus.wdata[BIT_USER_A]) && user_flag_b == $past(bus.wdata[BIT_USER_B]))
		else $error("user flag lost");
	a_divide_keep: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		cpu_clock_enable && alu_req.op == CSP_OP_DIVIDE && second_operand_reg == 8'h00
		|=> accumulator == $past(accumulator)) else $error("divide by zero changed accumulator");
	a_div_zero_over: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		cpu_clock_enable && alu_req.op == CSP_OP_DIVIDE && second_operand_reg == 8'h00 |=> overflow_flag)
		else $error("div zero no overflow");
	a_mul_clear_over: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		cpu_clock_enable && alu_req.op == CSP_OP_MULTIPLY && (accumulator * second_operand_reg) < 256
		|=> !overflow_flag) else $error("multiply overflow not cleared");
	a_stop_sticks: assert property (@(posedge core_clk) disable iff (reset)
		power_state == CSP_STOP && !internal_reset |=> power_state == CSP_STOP) else $error("stop left without reset");
	a_stop_gates: assert property (@(posedge core_clk) disable iff (reset)
		power_state == CSP_STOP |-> !cpu_clock_enable && !periph_clock_enable) else $error("clock runs in stop");
	a_stop_osc_off: assert property (@(posedge core_clk) disable iff (reset)
		power_state == CSP_STOP |=> !oscillator_enable) else $error("oscillator runs in stop");
	a_suspend_osc: assert property (@(posedge core_clk) disable iff (reset)
		power_state == CSP_SUSPEND |=> !oscillator_enable) else $error("oscillator runs in suspend");
	a_internal_restart: assert property (@(posedge core_clk) disable iff (reset)
		internal_reset |=> power_state == CSP_RUN && accumulator == RESET_BYTE && fetch_address == RESET_VECTOR)
		else $error("internal reset incomplete");
	a_idle_wake: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		power_state == CSP_IDLE && irq_sync[1] |=> cpu_clock_enable && power_state == CSP_RUN)
		else $error("idle wake late");
	a_idle_halts: assert property (@(posedge core_clk) disable iff (reset || internal_reset)
		power_state == CSP_RUN && instr_done && idle_pending && !stop_pending
		|=> power_state == CSP_IDLE && !cpu_clock_enable && periph_clock_enable) else $error("idle entry bad");
	a_bank_map: assert property (@(posedge core_clk) disable iff (reset)
		##1 bank_base == {$past(bank_select_hi), $past(bank_select_lo), 3'b000}) else $error("bank base bad");

endmodule

// file: sim/csp_core_status_tb.sv
// Register-level testbench for the core status and power block
`timescale 1ns/1ps
module tb
	import csp_pkg::*;
;
	// ==========================================================================
	// Signals and design
	logic            core_clk;
	logic            reset;
	csp_bus_type     bus;
	logic [7:0]      rdata;
	csp_alu_req_type alu_req;
	logic            instr_done;
	logic            irq_enabled_pin;
	logic            wake_event_pin;
	logic            watchdog_enable;
	logic            detector_enable;
	logic [15:0]     data_pointer;
	logic [4:0]      bank_base;
	logic            cpu_clock_enable;
	logic            periph_clock_enable;
	logic            oscillator_enable;
	logic            internal_reset;
	logic [15:0]     fetch_address;
	int              err_count;
	int              check_count;
	int              cycles;
	logic [7:0]      v;

	// Short counts keep the timeout scenarios brief
	csp_core_status #(.WATCHDOG_LIMIT(16), .DETECTOR_LIMIT(16)) dut (
		.core_clk            (core_clk),
		.reset               (reset),
		.bus                 (bus),
		.rdata               (rdata),
		.alu_req             (alu_req),
		.instr_done          (instr_done),
		.irq_enabled_pin     (irq_enabled_pin),
		.wake_event_pin      (wake_event_pin),
		.watchdog_enable     (watchdog_enable),
		.detector_enable     (detector_enable),
		.data_pointer        (data_pointer),
		.bank_base           (bank_base),
		.cpu_clock_enable    (cpu_clock_enable),
		.periph_clock_enable (periph_clock_enable),
		.oscillator_enable   (oscillator_enable),
		.internal_reset      (internal_reset),
		.fetch_address       (fetch_address)
	);

	// ==========================================================================
	// Clock, timeout and tasks
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
		@(posedge core_clk);
		bus <= '{addr: 8'h00, wdata: 8'h00, write: 1'b0, read: 1'b0};
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
		@(posedge core_clk);
		bus <= '{addr: 8'h00, wdata: 8'h00, write: 1'b0, read: 1'b0};
		@(posedge core_clk);
		d = rdata;
	endtask

	task automatic do_reset();
		reset <= 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
	endtask

	task automatic pulse_done();
		@(posedge core_clk);
		instr_done <= 1'b1;
		@(posedge core_clk);
		instr_done <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask

	// Flags compared as {carry, half carry, overflow} under a mask
	task automatic alu(input csp_op_type op, input logic [7:0] ps, input logic [7:0] a, input logic [7:0] b,
			input logic [7:0] o, input logic [7:0] ea, input logic [7:0] eb, input logic [2:0] ef,
			input logic [2:0] m);
		logic [7:0] va;
		logic [7:0] vs;
		wr(ADDR_STATUS_WORD, ps);
		wr(ADDR_ACCUMULATOR, a);
		wr(ADDR_SECOND_OP, b);
		@(posedge core_clk);
		alu_req <= '{op: op, operand: o};
		@(posedge core_clk);
		alu_req <= '{op: CSP_OP_NONE, operand: 8'h00};
		rd(ADDR_ACCUMULATOR, va);
		rd(ADDR_STATUS_WORD, vs);
		if (op != CSP_OP_OTHER_ARITH) chk("acc", 16'(va), 16'(ea));
		chk("flags", 16'({vs[7], vs[6], vs[2]} & m), 16'(ef & m));
		chk("parity", 16'(vs[0]), 16'(^va));
		if (op == CSP_OP_MULTIPLY || op == CSP_OP_DIVIDE) begin
			rd(ADDR_SECOND_OP, va);
			chk("second", 16'(va), 16'(eb));
		end
	endtask

	// ==========================================================================
	// Tests
	initial begin
		err_count = 0;
		check_count = 0;
		cycles = 0;
		bus = '{addr: 8'h00, wdata: 8'h00, write: 1'b0, read: 1'b0};
		alu_req = '{op: CSP_OP_NONE, operand: 8'h00};
		instr_done = 1'b0;
		irq_enabled_pin = 1'b0;
		wake_event_pin = 1'b0;
		watchdog_enable = 1'b0;
		detector_enable = 1'b0;
		do_reset();

		rd(ADDR_POINTER_HIGH, v);  chk("dph rst", 16'(v), 16'h0000);
		rd(ADDR_STATUS_WORD, v);   chk("psw rst", 16'(v), 16'h0000);
		rd(ADDR_ACCUMULATOR, v);   chk("acc rst", 16'(v), 16'h0000);
		rd(ADDR_SECOND_OP, v);     chk("b rst", 16'(v), 16'h0000);
		rd(8'h99, v);              chk("unmapped", 16'(v), 16'h0000);
		$display("test reset values done");

		wr(ADDR_POINTER_LOW, 8'h34);
		wr(ADDR_POINTER_HIGH, 8'h12);
		rd(ADDR_POINTER_HIGH, v);  chk("dph", 16'(v), 16'h0012);
		chk("pointer", data_pointer, 16'h1234);
		wr(ADDR_STATUS_WORD, 8'hff);
		rd(ADDR_STATUS_WORD, v);   chk("psw rw", 16'(v), 16'h00fe);
		wr(ADDR_ACCUMULATOR, 8'h07);
		rd(ADDR_STATUS_WORD, v);   chk("parity odd", 16'(v), 16'h00ff);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_STATUS_WORD, 8'(i << 3));
			repeat (2) @(posedge core_clk);
			chk("bank", 16'(bank_base), 16'(i * 8));
		end
		$display("test registers done");

		alu(CSP_OP_ADD, 8'h00, 8'h7f, 8'h00, 8'h01, 8'h80, 8'h00, 3'b011, 3'b111);
		alu(CSP_OP_ADD, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 3'b101, 3'b111);
		alu(CSP_OP_ADD, 8'h04, 8'h0f, 8'h00, 8'h01, 8'h10, 8'h00, 3'b010, 3'b111);
		alu(CSP_OP_ADD_WITH_CARRY, 8'h80, 8'h01, 8'h00, 8'h01, 8'h03, 8'h00, 3'b000, 3'b111);
		alu(CSP_OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 3'b110, 3'b111);
		alu(CSP_OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h00, 3'b011, 3'b111);
		alu(CSP_OP_MULTIPLY, 8'h00, 8'h20, 8'h10, 8'h10, 8'h00, 8'h02, 3'b001, 3'b001);
		alu(CSP_OP_MULTIPLY, 8'h04, 8'h02, 8'h03, 8'h03, 8'h06, 8'h00, 3'b000, 3'b001);
		alu(CSP_OP_DIVIDE, 8'h00, 8'h09, 8'h00, 8'h00, 8'h09, 8'h00, 3'b001, 3'b001);
		alu(CSP_OP_DIVIDE, 8'h04, 8'h09, 8'h02, 8'h02, 8'h04, 8'h01, 3'b000, 3'b001);
		alu(CSP_OP_OTHER_ARITH, 8'hc4, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 3'b001, 3'b111);
		$display("test arithmetic flags done");

		wr(ADDR_ACCUMULATOR, 8'h5a);
		wr(ADDR_POWER_CONTROL, 8'h01);
		rd(ADDR_POWER_CONTROL, v); chk("power_control read", 16'(v), 16'h0000);
		pulse_done();
		chk("idle cpu", 16'(cpu_clock_enable), 16'h0000);
		chk("idle periph", 16'(periph_clock_enable), 16'h0001);
		rd(ADDR_POWER_STATE, v);   chk("idle state", 16'(v), 16'h0001);
		rd(ADDR_ACCUMULATOR, v);   chk("idle keep", 16'(v), 16'h005a);
		irq_enabled_pin <= 1'b1;
		for (int i = 0; i < 6 && cpu_clock_enable !== 1'b1; i++) @(posedge core_clk);
		chk("wake cpu", 16'(cpu_clock_enable), 16'h0001);
		irq_enabled_pin <= 1'b0;
		rd(ADDR_POWER_STATE, v);   chk("run state", 16'(v), 16'h0000);
		$display("test idle and wake done");

		wr(ADDR_POWER_CONTROL, 8'h01);
		pulse_done();
		watchdog_enable <= 1'b1;
		for (int i = 0; i < 40 && internal_reset !== 1'b1; i++) @(posedge core_clk);
		chk("watchdog", 16'(internal_reset), 16'h0001);
		watchdog_enable <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("wd cpu", 16'(cpu_clock_enable), 16'h0001);
		chk("wd fetch", fetch_address, 16'h0000);
		rd(ADDR_ACCUMULATOR, v);   chk("wd acc", 16'(v), 16'h0000);
		$display("test watchdog in idle done");

		wr(ADDR_POWER_CONTROL, 8'h02);
		pulse_done();
		chk("stop osc", 16'(oscillator_enable), 16'h0000);
		chk("stop periph", 16'(periph_clock_enable), 16'h0000);
		irq_enabled_pin <= 1'b1;
		repeat (10) @(posedge core_clk);
		chk("stop irq", 16'(cpu_clock_enable), 16'h0000);
		irq_enabled_pin <= 1'b0;
		detector_enable <= 1'b1;
		for (int i = 0; i < 40 && internal_reset !== 1'b1; i++) @(posedge core_clk);
		chk("detector", 16'(internal_reset), 16'h0001);
		detector_enable <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("det osc", 16'(oscillator_enable), 16'h0001);
		wr(ADDR_POWER_CONTROL, 8'h02);
		pulse_done();
		do_reset();
		@(posedge core_clk);
		chk("rst osc", 16'(oscillator_enable), 16'h0001);
		chk("rst fetch", fetch_address, 16'h0000);
		$display("test stop done");

		wr(ADDR_POWER_STATE, 8'h01);
		pulse_done();
		chk("suspend osc", 16'(oscillator_enable), 16'h0000);
		repeat (5) @(posedge core_clk);
		chk("suspend hold", 16'(oscillator_enable), 16'h0000);
		wake_event_pin <= 1'b1;
		for (int i = 0; i < 8 && oscillator_enable !== 1'b1; i++) @(posedge core_clk);
		chk("suspend wake", 16'(oscillator_enable), 16'h0001);
		wake_event_pin <= 1'b0;
		$display("test suspend done");
		wrap_up();
	end
endmodule
